// ==== core/fmbe_defs.vh ====
// register map, field positions, codes and reset values of the flash erase sequencer
`ifndef FMBE_DEFS_VH
`define FMBE_DEFS_VH

// register byte offsets
`define FMBE_OFS_DIV      5'h00
`define FMBE_OFS_CFG      5'h04
`define FMBE_OFS_STAT     5'h08
`define FMBE_OFS_IDX      5'h0C
`define FMBE_OFS_PARAM    5'h10
`define FMBE_OFS_SEC      5'h14
`define FMBE_OFS_PROT     5'h18

// clock divider fields
`define FMBE_DIV_LOADED   7
`define FMBE_DIV_RST      7'h00

// config fields
`define FMBE_CFG_PEND     0

// status fields
`define FMBE_ST_CCF       7
`define FMBE_ST_ACC       5
`define FMBE_ST_PVL       4
`define FMBE_ST_VER       1
`define FMBE_ST_VUN       0

// protection fields
`define FMBE_PROT_PF      0
`define FMBE_PROT_EE      1
`define FMBE_PROT_RST     2'h0

// security state field codes
`define FMBE_SEC_SECURED  2'h0
`define FMBE_SEC_UNSEC    2'h2
`define FMBE_SECBYTE_UNS  8'hFE

// command codes and parameter index demands
`define FMBE_CMD_ERS_ALL  8'h08
`define FMBE_CMD_ERS_BLK  8'h09
`define FMBE_IDX_ERS_ALL  3'h0
`define FMBE_IDX_ERS_BLK  3'h1

// array operation codes
`define FMBE_OP_ERS_ALL   2'h0
`define FMBE_OP_ERS_BLK   2'h1
`define FMBE_OP_PRG_SEC   2'h2

// global address windows of the two arrays
`define FMBE_PF_LO        24'hFC0000
`define FMBE_PF_HI        24'hFFFFFF
`define FMBE_EE_LO        24'h100000
`define FMBE_EE_HI        24'h1007FF

`endif

// ==== core/fmbe_param_mem.v ====
// small memory holding the command parameter words, registered read port
`timescale 1ns/1ps
module fmbe_param_mem #(
	parameter W  = 16,
	parameter D  = 8,
	parameter AW = 3
) (
	input  wire          i_clk_sys,
	input  wire          i_rst,
	input  wire          i_we,
	input  wire [AW-1:0] i_waddr,
	input  wire [W-1:0]  i_wdata,
	input  wire [AW-1:0] i_raddr,
	output reg  [W-1:0]  o_rdata
);

	reg [W-1:0] mem [0:D-1];  // storage, no reset needed

	// write port
	always @(posedge i_clk_sys) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
	end

	// read port: data come one cycle after the address
	always @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= {W{1'b0}};
		end else begin
			o_rdata <= mem[i_raddr];
		end
	end

endmodule

// ==== core/fmbe_erase_seq.v ====
// erase-all and block-erase command sequencer with its register slave
//
// Summary of operation
// - command 0x08 erases everything, then verifies
// - passing erase-all verify releases device security
// - completion flag sets only after verify ends
// - erase-all needs index 000, else access error
// - disallowed mode gives access error
// - any protection refuses erase-all, protection error
// - verify errors and uncorrectable errors flagged
// - request pin performs erase-all without command
// - divider unloaded: skip request, access error
// - request erase resets divider; host reloads it
// - request erase ignores protection settings
// - request pass: unsecure field, program security byte
// - pending bit shows request, clears on completion
// - protection configuration untouched by request erase
// - verify flags cover erase and byte program
// - command 0x09 erases one block, address split
// - block erase needs index 001, else error
// - invalid block address gives access error
// - misaligned block address gives access error
// - protected block refuses erase, protection error
`timescale 1ns/1ps
`include "fmbe_defs.vh"
module fmbe_erase_seq #(
	parameter PF_LO = `FMBE_PF_LO,
	parameter PF_HI = `FMBE_PF_HI,
	parameter EE_LO = `FMBE_EE_LO,
	parameter EE_HI = `FMBE_EE_HI
) (
	input  wire        i_clk_sys,
	input  wire        i_rst,
	input  wire [4:0]  i_addr,
	input  wire [15:0] i_wdata,
	input  wire        i_wr,
	input  wire        i_rd,
	output reg  [15:0] o_rd_data,
	input  wire        i_erase_all_req,
	input  wire        i_mode_ok,
	output reg         o_arr_start,
	output reg  [1:0]  o_arr_op,
	output reg  [23:0] o_arr_addr,
	output reg  [7:0]  o_arr_wdata,
	input  wire        i_arr_done,
	input  wire        i_arr_vfy_err,
	input  wire        i_arr_vfy_uncorr,
	output wire [1:0]  o_sec_state,
	output wire        o_busy
);

	// sequencer states
	localparam S_IDLE  = 4'h0;
	localparam S_FETCH = 4'h1;
	localparam S_WAIT  = 4'h2;
	localparam S_DEC   = 4'h3;
	localparam S_START = 4'h4;
	localparam S_RUN   = 4'h5;
	localparam S_SECP  = 4'h6;
	localparam S_SECW  = 4'h7;
	localparam S_FIN   = 4'h8;

	reg  [3:0]  state;        // sequencer state
	reg  [6:0]  div_val;      // flash clock divider value
	reg         div_loaded;   // divider written since reset or mass erase
	reg         ccf;          // command complete flag
	reg         acc_err;      // access error flag
	reg         prot_viol;    // protection violation flag
	reg         ver_err;      // verify error flag
	reg         ver_unc;      // verify uncorrectable flag
	reg  [2:0]  pidx;         // parameter word index
	reg  [1:0]  prot;         // protection config, pflash and eeprom
	reg  [1:0]  sec_state;    // security state field
	reg         pending;      // mass erase pending
	reg         mass_act;     // running sequence came from the pin
	reg  [15:0] w0;           // first parameter word
	reg  [2:0]  rd_idx;       // sequencer read index into param memory
	reg         rq_s1;        // request synchroniser stage 1
	reg         rq_s2;        // request synchroniser stage 2
	reg         rq_s3;        // request synchroniser stage 3
	reg         rq_lvl;       // filtered request level
	wire [15:0] mem_rdata;    // param memory read data
	wire        rq_rise;      // filtered request rising edge
	wire        wr_div;       // register write decodes
	wire        wr_stat;
	wire        wr_idx;
	wire        wr_param;
	wire        wr_prot;
	wire        launch;       // software launch of a command
	wire [7:0]  cmd;          // command code from first word
	wire [23:0] gaddr;        // global address from both words

	// address lies in one of the two arrays
	function addr_in_pf;
		input [23:0] a;
		begin
			addr_in_pf = (a >= PF_LO) && (a <= PF_HI);
		end
	endfunction

	function addr_in_ee;
		input [23:0] a;
		begin
			addr_in_ee = (a >= EE_LO) && (a <= EE_HI);
		end
	endfunction

	// host writes are honoured only while no command runs
	assign wr_div   = i_wr && ccf && (i_addr == `FMBE_OFS_DIV);
	assign wr_stat  = i_wr && ccf && (i_addr == `FMBE_OFS_STAT);
	assign wr_idx   = i_wr && ccf && (i_addr == `FMBE_OFS_IDX);
	assign wr_param = i_wr && ccf && (i_addr == `FMBE_OFS_PARAM);
	assign wr_prot  = i_wr && ccf && (i_addr == `FMBE_OFS_PROT);

	// a launch with access or protection error still set is ignored, as is one during a request
	assign launch = wr_stat && i_wdata[`FMBE_ST_CCF] && !acc_err && !prot_viol
		&& !pending && (state == S_IDLE);

	assign cmd         = w0[15:8];
	assign gaddr       = {w0[7:0], mem_rdata};
	assign o_sec_state = sec_state;
	assign o_busy      = !ccf;

	// parameter words, written at the current index
	fmbe_param_mem #(
		.W  (16),
		.D  (8),
		.AW (3)
	) u_param (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_we      (wr_param),
		.i_waddr   (pidx),
		.i_wdata   (i_wdata),
		.i_raddr   (rd_idx),
		.o_rdata   (mem_rdata)
	);

	// request pin: three flops, level changes once stages two and three agree
	always @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			rq_s1  <= 1'b0;
			rq_s2  <= 1'b0;
			rq_s3  <= 1'b0;
			rq_lvl <= 1'b0;
		end else begin
			rq_s1 <= i_erase_all_req;
			rq_s2 <= rq_s1;
			rq_s3 <= rq_s2;
			if (rq_s2 == rq_s3) begin
				rq_lvl <= rq_s3;
			end
		end
	end

	// only a fresh assertion starts a sequence; holding the pin does not repeat it
	assign rq_rise = (rq_s2 == rq_s3) && rq_s3 && !rq_lvl;

	// sequencer and control registers share one process so every bit has one driver
	always @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			state       <= S_IDLE;
			div_val     <= `FMBE_DIV_RST;
			div_loaded  <= 1'b0;
			ccf         <= 1'b1;
			acc_err     <= 1'b0;
			prot_viol   <= 1'b0;
			ver_err     <= 1'b0;
			ver_unc     <= 1'b0;
			pidx        <= 3'h0;
			prot        <= `FMBE_PROT_RST;
			sec_state   <= `FMBE_SEC_SECURED;
			pending     <= 1'b0;
			mass_act    <= 1'b0;
			w0          <= 16'h0000;
			rd_idx      <= 3'h0;
			o_arr_start <= 1'b0;
			o_arr_op    <= `FMBE_OP_ERS_ALL;
			o_arr_addr  <= 24'h000000;
			o_arr_wdata <= 8'h00;
		end else begin
			o_arr_start <= 1'b0;
			// plain software registers
			if (wr_div) begin
				div_val    <= i_wdata[6:0];
				div_loaded <= 1'b1;
			end
			if (wr_idx) begin
				pidx <= i_wdata[2:0];
			end
			if (wr_prot) begin
				prot <= i_wdata[1:0];
			end
			// write one clears the access and protection error flags; a set below wins
			if (wr_stat && i_wdata[`FMBE_ST_ACC]) begin
				acc_err <= 1'b0;
			end
			if (wr_stat && i_wdata[`FMBE_ST_PVL]) begin
				prot_viol <= 1'b0;
			end
			// pending bit is set by a fresh pin assertion; set wins over the completion clear
			if (rq_rise) begin
				pending <= 1'b1;
			end
			case (state)
				S_IDLE: begin
					rd_idx <= 3'h0;
					if (pending && !rq_rise && !mass_act) begin
						if (!div_loaded || !i_mode_ok) begin
							acc_err <= 1'b1;
							pending <= 1'b0;
						end else begin
							// protection is neither checked nor changed on this path
							ccf         <= 1'b0;
							mass_act    <= 1'b1;
							ver_err     <= 1'b0;
							ver_unc     <= 1'b0;
							o_arr_op    <= `FMBE_OP_ERS_ALL;
							o_arr_addr  <= 24'h000000;
							state       <= S_START;
						end
					end else if (launch) begin
						ccf     <= 1'b0;
						ver_err <= 1'b0;
						ver_unc <= 1'b0;
						state   <= S_FETCH;
					end
				end
				S_FETCH: begin
					// memory output now holds word zero
					w0     <= mem_rdata;
					rd_idx <= 3'h1;
					state  <= S_WAIT;
				end
				S_WAIT: begin
					// word one is on its way out of the memory
					state <= S_DEC;
				end
				S_DEC: begin
					o_arr_addr <= gaddr;
					if (cmd == `FMBE_CMD_ERS_ALL) begin
						if (pidx != `FMBE_IDX_ERS_ALL || !i_mode_ok || !div_loaded) begin
							acc_err <= 1'b1;
							state   <= S_FIN;
						end else if (prot != 2'h0) begin
							prot_viol <= 1'b1;
							state     <= S_FIN;
						end else begin
							o_arr_op   <= `FMBE_OP_ERS_ALL;
							// word one is not needed here, so a stale address must not leak out
							o_arr_addr <= 24'h000000;
							state      <= S_START;
						end
					end else if (cmd == `FMBE_CMD_ERS_BLK) begin
						if (pidx != `FMBE_IDX_ERS_BLK || !i_mode_ok || !div_loaded) begin
							acc_err <= 1'b1;
							state   <= S_FIN;
						end else if (!addr_in_pf(gaddr) && !addr_in_ee(gaddr)) begin
							acc_err <= 1'b1;
							state   <= S_FIN;
						end else if ((addr_in_pf(gaddr) && gaddr[2:0] != 3'h0)
							|| (addr_in_ee(gaddr) && gaddr[0])) begin
							acc_err <= 1'b1;
							state   <= S_FIN;
						end else if ((addr_in_pf(gaddr) && prot[`FMBE_PROT_PF])
							|| (addr_in_ee(gaddr) && prot[`FMBE_PROT_EE])) begin
							prot_viol <= 1'b1;
							state     <= S_FIN;
						end else begin
							o_arr_op <= `FMBE_OP_ERS_BLK;
							state    <= S_START;
						end
					end else begin
						// other command codes are not served by this sequencer
						acc_err <= 1'b1;
						state   <= S_FIN;
					end
				end
				S_START: begin
					o_arr_start <= 1'b1;
					state       <= S_RUN;
				end
				S_RUN: begin
					// erase and its verify run inside the array
					if (i_arr_done) begin
						ver_err <= ver_err | i_arr_vfy_err;
						ver_unc <= ver_unc | i_arr_vfy_uncorr;
						if (o_arr_op == `FMBE_OP_ERS_ALL && !i_arr_vfy_err) begin
							sec_state <= `FMBE_SEC_UNSEC;
							state     <= mass_act ? S_SECP : S_FIN;
						end else begin
							state <= S_FIN;
						end
					end
				end
				S_SECP: begin
					// store the unsecure byte so security stays released after reset
					o_arr_op    <= `FMBE_OP_PRG_SEC;
					o_arr_wdata <= `FMBE_SECBYTE_UNS;
					o_arr_start <= 1'b1;
					state       <= S_SECW;
				end
				S_SECW: begin
					if (i_arr_done) begin
						ver_err <= ver_err | i_arr_vfy_err;
						ver_unc <= ver_unc | i_arr_vfy_uncorr;
						state   <= S_FIN;
					end
				end
				S_FIN: begin
					ccf <= 1'b1;
					if (mass_act) begin
						mass_act   <= 1'b0;
						div_val    <= `FMBE_DIV_RST;
						div_loaded <= 1'b0;
						if (!rq_rise) begin
							pending <= 1'b0;
						end
					end
					state <= S_IDLE;
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end

	// register read data, one cycle after the read strobe; unmapped reads zero
	always @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_rd_data <= 16'h0000;
		end else if (i_rd) begin
			case (i_addr)
				`FMBE_OFS_DIV:  o_rd_data <= {8'h00, div_loaded, div_val};
				`FMBE_OFS_CFG:  o_rd_data <= {15'h0000, pending};
				`FMBE_OFS_STAT: o_rd_data <= {8'h00, ccf, 1'b0, acc_err, prot_viol,
					2'h0, ver_err, ver_unc};
				`FMBE_OFS_IDX:  o_rd_data <= {13'h0000, pidx};
				`FMBE_OFS_SEC:  o_rd_data <= {14'h0000, sec_state};
				`FMBE_OFS_PROT: o_rd_data <= {14'h0000, prot};
				default:        o_rd_data <= 16'h0000;
			endcase
		end else begin
			o_rd_data <= 16'h0000;
		end
	end

endmodule

// ==== sim/fmbe_erase_seq_asserts.sv ====
// port assertions for the erase sequencer
`timescale 1ns/1ps
module fmbe_erase_seq_asserts (
	input logic        i_clk_sys,
	input logic        i_rst,
	input logic        i_rd,
	input logic [15:0] o_rd_data,
	input logic        o_arr_start,
	input logic [1:0]  o_arr_op,
	input logic [23:0] o_arr_addr,
	input logic [7:0]  o_arr_wdata,
	input logic        i_arr_done,
	input logic [1:0]  o_sec_state,
	input logic        o_busy
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	// last array answer closes the command within three cycles
	sequence s_finish;
		##[1:3] !o_busy;
	endsequence
	a_start_single: assert property (o_arr_start |=> !o_arr_start) else $error("start pulse too long");
	a_start_busy: assert property (o_arr_start |-> o_busy ##1 o_busy) else $error("start while complete");
	a_op_held: assert property (o_arr_start |=> $stable(o_arr_op) && $stable(o_arr_addr)) else $error("op moved");
	a_all_addr: assert property (o_arr_start && o_arr_op == 2'h0 |-> o_arr_addr == 24'h0)
		else $error("erase all address");
	a_sec_byte: assert property (o_arr_start && o_arr_op == 2'h2 |-> o_arr_wdata == 8'hFE && o_sec_state == 2'h2)
		else $error("security byte");
	a_last_finish: assert property (i_arr_done && o_busy && o_arr_op != 2'h0 |-> s_finish)
		else $error("no completion");
	a_blk_valid: assert property (o_arr_start && o_arr_op == 2'h1 |->
		(o_arr_addr >= 24'hFC0000 && o_arr_addr[2:0] == 3'h0) ||
		(o_arr_addr >= 24'h100000 && o_arr_addr <= 24'h1007FF && !o_arr_addr[0])) else $error("bad block");
	a_rd_quiet: assert property (!$past(i_rd) |-> o_rd_data == 16'h0) else $error("read data outside slot");
	a_idle_quiet: assert property (!o_busy |-> !o_arr_start) else $error("start while idle");
endmodule
bind fmbe_erase_seq fmbe_erase_seq_asserts u_chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_rd(i_rd),
	.o_rd_data(o_rd_data), .o_arr_start(o_arr_start), .o_arr_op(o_arr_op), .o_arr_addr(o_arr_addr),
	.o_arr_wdata(o_arr_wdata), .i_arr_done(i_arr_done), .o_sec_state(o_sec_state), .o_busy(o_busy));

// ==== sim/fmbe_array_model.sv ====
// stand-in for the flash array: answers start pulses with done and verify results
`timescale 1ns/1ps
module fmbe_array_model (
	input  logic        i_clk_sys,
	input  logic        i_rst,
	input  logic        i_start,
	input  logic [1:0]  i_op,
	input  logic [23:0] i_addr,
	input  logic        i_slow,
	input  logic [1:0]  i_fail,
	output logic        o_done,
	output logic        o_vfy_err,
	output logic        o_vfy_uncorr,
	output logic [1:0]  o_last_op,
	output logic [23:0] o_last_addr
);
	logic [3:0] cnt; // cycles left, 0 = idle
	logic       tog; // filler so stale qualifiers never look valid
	assign o_vfy_err    = o_done ? i_fail[0] : tog;
	assign o_vfy_uncorr = o_done ? i_fail[1] : ~tog;
	// slow mode stretches the operation to show waiting is honoured
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			cnt <= 4'h0;
			tog <= 1'b0;
			o_done <= 1'b0;
			o_last_op <= 2'h3;
			o_last_addr <= 24'h0;
		end else begin
			o_done <= 1'b0;
			tog <= ~tog;
			if (i_start) begin
				cnt <= i_slow ? 4'h6 : 4'h1;
				o_last_op <= i_op;
				o_last_addr <= i_addr;
			end else if (cnt == 4'h1) begin
				cnt <= 4'h0;
				o_done <= 1'b1;
			end else if (cnt != 4'h0) begin
				cnt <= cnt - 4'h1;
			end
		end
	end
endmodule

// ==== sim/fmbe_erase_seq_tb.sv ====
// self-checking bench for the erase sequencer
`timescale 1ns/1ps
module fmbe_erase_seq_tb;
	logic        i_clk_sys = 1'b0;
	logic        i_rst = 1'b1;
	logic [4:0]  i_addr = 5'h0;
	logic [15:0] i_wdata = 16'h0;
	logic        i_wr = 1'b0, i_rd = 1'b0, i_erase_all_req = 1'b0, i_mode_ok = 1'b1, slow = 1'b0;
	logic [1:0]  fail = 2'h0;
	wire  [15:0] o_rd_data;
	wire         o_arr_start, done, verr, vunc, o_busy;
	wire  [1:0]  o_arr_op, o_sec_state, last_op;
	wire  [23:0] o_arr_addr, last_addr;
	wire  [7:0]  o_arr_wdata;
	int          error_cnt = 0, checks_done = 0;
	// block erase cases: address, index, protection, expected status
	logic [23:0] ba [7] = '{24'hFC0008, 24'hFC0004, 24'h100002, 24'h100001, 24'h200000, 24'hFC0000, 24'h100000};
	logic [2:0]  bi [7] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h0, 3'h1};
	logic [15:0] bp [7] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h2};
	logic [15:0] bs [7] = '{16'h0080, 16'h00A0, 16'h0080, 16'h00A0, 16'h00A0, 16'h00A0, 16'h0090};
	always #25 i_clk_sys = ~i_clk_sys;
	fmbe_erase_seq uut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rd_data(o_rd_data), .i_erase_all_req(i_erase_all_req), .i_mode_ok(i_mode_ok),
		.o_arr_start(o_arr_start), .o_arr_op(o_arr_op), .o_arr_addr(o_arr_addr), .o_arr_wdata(o_arr_wdata),
		.i_arr_done(done), .i_arr_vfy_err(verr), .i_arr_vfy_uncorr(vunc), .o_sec_state(o_sec_state), .o_busy(o_busy));
	fmbe_array_model u_arr (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_start(o_arr_start), .i_op(o_arr_op),
		.i_addr(o_arr_addr), .i_slow(slow), .i_fail(fail), .o_done(done), .o_vfy_err(verr), .o_vfy_uncorr(vunc),
		.o_last_op(last_op), .o_last_addr(last_addr));
	task chk(input logic [23:0] got, input logic [23:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge i_clk_sys);
		i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
	endtask
	// read data is only valid in the cycle after the strobe
	task rd(input logic [4:0] a, input logic [15:0] e);
		@(posedge i_clk_sys);
		i_addr <= a; i_rd <= 1'b1;
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		@(negedge i_clk_sys);
		chk(o_rd_data, e);
		// hand back on a rising edge so callers drive design inputs there
		@(posedge i_clk_sys);
	endtask
	// host keeps off the bus until the operation ends
	task idle;
		repeat (8) @(negedge i_clk_sys);
		for (int n = 0; n < 300 && o_busy !== 1'b0; n++) @(negedge i_clk_sys);
		if (o_busy !== 1'b0) chk(24'h1, 24'h0);
	endtask
	task cmd(input logic [2:0] ix, input logic [15:0] w0, input logic [15:0] w1, input logic [15:0] st);
		wr(5'h0C, 16'h0); wr(5'h10, w0); wr(5'h0C, 16'h1); wr(5'h10, w1); wr(5'h0C, {13'h0, ix});
		wr(5'h08, 16'h0080);
		idle;
		rd(5'h08, st);
		wr(5'h08, 16'h0030); // clear sticky flags, otherwise the next launch is ignored
	endtask
	task do_reset;
		i_rst <= 1'b1;
		repeat (6) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		rd(5'h08, 16'h0080);
		rd(5'h00, 16'h0000);
		chk(o_sec_state, 24'h0);
		wr(5'h00, 16'h0010);
	endtask
	task t_all_err;
		fail <= 2'h1;
		cmd(3'h0, 16'h0800, 16'h0, 16'h0082);
		fail <= 2'h3;
		cmd(3'h0, 16'h0800, 16'h0, 16'h0083);
		chk(o_sec_state, 24'h0);
		fail <= 2'h0;
	endtask
	task t_all_refuse;
		cmd(3'h1, 16'h0800, 16'h0, 16'h00A0);
		i_mode_ok <= 1'b0;
		cmd(3'h0, 16'h0800, 16'h0, 16'h00A0);
		cmd(3'h1, 16'h09FC, 16'h0000, 16'h00A0);
		i_mode_ok <= 1'b1;
		wr(5'h18, 16'h0001);
		cmd(3'h0, 16'h0800, 16'h0, 16'h0090);
	endtask
	task t_blk;
		for (int k = 0; k < 7; k++) begin
			slow <= k[0];
			wr(5'h18, bp[k]);
			cmd(bi[k], {8'h09, ba[k][23:16]}, ba[k][15:0], bs[k]);
			if (bs[k] == 16'h0080) chk(last_addr, ba[k]);
		end
	endtask
	task t_pin;
		slow <= 1'b1;
		wr(5'h18, 16'h0003);
		i_erase_all_req <= 1'b1; // flags were cleared beforehand
		repeat (6) @(posedge i_clk_sys);
		rd(5'h04, 16'h0001);
		idle;
		rd(5'h04, 16'h0000);
		rd(5'h08, 16'h0080);
		chk(last_op, 24'h2);
		chk(o_sec_state, 24'h2);
		chk(o_arr_wdata, 24'hFE);
		rd(5'h00, 16'h0000);
		rd(5'h18, 16'h0003);
		i_erase_all_req <= 1'b0;
		repeat (8) @(posedge i_clk_sys);
		i_erase_all_req <= 1'b1;
		repeat (14) @(posedge i_clk_sys);
		rd(5'h08, 16'h00A0);
		rd(5'h04, 16'h0000);
		i_erase_all_req <= 1'b0;
	endtask
	task t_all_pass;
		do_reset;
		cmd(3'h0, 16'h0800, 16'h1234, 16'h0080);
		chk(last_op, 24'h0);
		chk(last_addr, 24'h0);
		chk(o_sec_state, 24'h2);
	endtask
	// erase passes, then the security byte program fails: verify flags must show it
	task t_pin_prog;
		wr(5'h00, 16'h0010);
		i_erase_all_req <= 1'b1;
		for (int n = 0; n < 100 && o_arr_op !== 2'h2; n++) @(negedge i_clk_sys);
		fail <= 2'h3;
		idle;
		rd(5'h08, 16'h0083);
		chk(o_sec_state, 24'h2);
		fail <= 2'h0;
		i_erase_all_req <= 1'b0;
	endtask
	task print_verdict;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		do_reset;
		t_all_err;
		t_all_refuse;
		t_blk;
		t_pin;
		t_all_pass;
		t_pin_prog;
		print_verdict;
	end
	// whole run is a few hundred cycles; this limit of 20000 cycles cuts a hang short
	initial begin
		#1000000;
		error_cnt++;
		print_verdict;
	end
endmodule
